// >>> include/psled_defines.svh
// constants of the phy status indicator block: clock, hold times, register map
// assumes the includer has the package types available where needed
`ifndef PSLED_DEFINES_SVH
`define PSLED_DEFINES_SVH

`define PSL_CLK_HZ      10000000
`define PSL_STRETCH_MS  50
`define PSL_STRETCH_CYC (`PSL_STRETCH_MS * (`PSL_CLK_HZ / 1000))
`define PSL_QUAL_US     500
`define PSL_QUAL_CYC    (((`PSL_QUAL_US * (`PSL_CLK_HZ / 1000)) + 999) / 1000)
`define PSL_LOSS_MS     100
`define PSL_LOSS_CYC    (`PSL_LOSS_MS * (`PSL_CLK_HZ / 1000))
`define PSL_CNT_W       20
`define PSL_QCNT_W      13
`define PSL_LP_NEED     3'h7

`define PSL_IDX_PCS     8'h16
`define PSL_IDX_CTL     8'h19
`define PSL_IDX_STAT    8'h1a
`define PSL_CTL_TXMAP   7
`define PSL_CTL_DUPSEL  6
`define PSL_PCS_CIS     4
`define PSL_CTL_RST_HI  2'h1

`define PSL_COL         0
`define PSL_TX          1
`define PSL_RX          2
`define PSL_LINK        3
`define PSL_FDP         4

`endif

// >>> include/psled_pkg.sv
// types shared by the phy status indicator block
// assumes nothing beyond a SystemVerilog compiler
package psled_pkg;
	typedef enum logic [1:0] {
		PSLED_DOWN = 2'b00,
		PSLED_QUAL = 2'b01,
		PSLED_UP   = 2'b11
	} psled_link_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} psled_bus_t;

	typedef struct packed {
		logic speed_10;
		logic full_duplex;
		logic aui;
		logic fx;
	} psled_mode_t;

	typedef struct packed {
		logic collision;
		logic heartbeat;
		logic tx_act;
		logic rx_act;
		logic link_pulse;
		logic valid_pkt;
		logic sig_detect;
		logic cipher_sync;
		logic fx_sig_detect;
		logic polarity_inv;
		logic carrier_integrity;
	} psled_evt_t;
endpackage : psled_pkg

// >>> rtl/psled_top.sv
// status indicator driver of a 10/100 ethernet phy: five indicators, speed pin
// assumes all inputs synchronous to clk_in; strap levels valid while srst_in is high
//
// How it works
// - strap low gives active high, high gives low
// - collision shown in half duplex, both speeds
// - collision never shown in full duplex
// - heartbeat after transmit lights collision at 10M
// - collision held about 50 ms
// - transmit activity shown at both speeds
// - remap bit shows carrier integrity on transmit
// - transmit held about 50 ms
// - any receive activity shown
// - receive held about 50 ms
// - 100TX link after 500 us detect plus sync
// - 100TX link held by detect, drops at once
// - 10M link on seven pulses or packet
// - 10M link drops when loss timer expires
// - fiber link after 500 us external detect
// - AUI holds link indicator on
// - duplex select picks duplex or polarity
// - polarity inversion corrected and indicated at 10M only
// - speed pin high at 10M, low 100M
// - straps captured into control low bits
`timescale 1ns/100ps
`default_nettype none
`include "psled_defines.svh"

module psled_top
#(
	parameter int unsigned STRETCH_CYC = `PSL_STRETCH_CYC,
	parameter int unsigned QUAL_CYC    = `PSL_QUAL_CYC,
	parameter int unsigned LOSS_CYC    = `PSL_LOSS_CYC
)
(
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	// register port
	input  wire psled_pkg::psled_bus_t bus_in,
	output logic [7:0]                 rd_data_out,
	// line state
	input  wire psled_pkg::psled_mode_t mode_in,
	input  wire psled_pkg::psled_evt_t  evt_in,
	input  wire logic [4:0]            address_strap_in,
	// indicator pins
	output logic                       collision_indicator_out,
	output logic                       transmit_indicator_out,
	output logic                       receive_indicator_out,
	output logic                       link_indicator_out,
	output logic                       duplex_polarity_indicator_out,
	output logic                       indicator_oe_out,
	output logic                       low_speed_output_out,
	output logic                       rx_polarity_flip_out
);
	import psled_pkg::*;

	typedef struct packed {
		logic [4:0]            strap;
		logic                  tx_remap;
		logic                  dup_sel;
		logic [`PSL_CNT_W-1:0] col_cnt;
		logic [`PSL_CNT_W-1:0] tx_cnt;
		logic [`PSL_CNT_W-1:0] rx_cnt;
		logic [`PSL_QCNT_W-1:0] qual_cnt;
		logic [`PSL_CNT_W-1:0] loss_cnt;
		logic [2:0]            lp_cnt;
		psled_link_t           lstate;
		logic [4:0]            act;
		logic [4:0]            pin;
		logic                  oe;
		logic                  speed;
		logic                  pol_flip;
		logic [7:0]            rdata;
	} psled_state_t;

	localparam logic [`PSL_CNT_W-1:0]  HOLD = STRETCH_CYC[`PSL_CNT_W-1:0];
	localparam logic [`PSL_QCNT_W-1:0] QEND = QUAL_CYC[`PSL_QCNT_W-1:0] - 1'b1;
	localparam logic [`PSL_CNT_W-1:0]  LOSS = LOSS_CYC[`PSL_CNT_W-1:0];

	psled_state_t st_r;
	psled_state_t st_nxt;

	// retriggerable hold counter: an event reloads, otherwise count down to zero
	function automatic logic [`PSL_CNT_W-1:0] stretch
	(
		input logic [`PSL_CNT_W-1:0] cnt,
		input logic                  ev
	);
		if (ev)
			return HOLD;
		else if (cnt != '0)
			return cnt - 1'b1;
		else
			return '0;
	endfunction : stretch

	function automatic logic [7:0] byte_addr
	(
		input logic [7:0] idx
	);
		return {idx[5:0], 2'b00};
	endfunction : byte_addr

	logic       col_ev;
	logic       tx_ev;
	logic       rx_ev;
	logic       lp_ev;
	logic       qual_ok;
	logic       hold_ok;
	logic       link_on;
	logic       is_10t;
	logic [7:0] ctl_val;
	logic [7:0] pcs_val;
	logic [7:0] stat_val;

	always_comb
	begin
		st_nxt   = st_r;
		col_ev   = ~mode_in.full_duplex &
		           (evt_in.collision | (mode_in.speed_10 & evt_in.heartbeat));
		tx_ev    = evt_in.tx_act;
		rx_ev    = evt_in.rx_act;
		lp_ev    = evt_in.link_pulse | evt_in.valid_pkt;
		is_10t   = mode_in.speed_10 & ~mode_in.aui;
		// fiber qualifies on the external detect alone, twisted pair also needs sync
		qual_ok  = mode_in.fx ? evt_in.fx_sig_detect
		                      : (evt_in.sig_detect & evt_in.cipher_sync);
		hold_ok  = mode_in.fx ? evt_in.fx_sig_detect : evt_in.sig_detect;
		ctl_val  = {st_r.tx_remap, st_r.dup_sel, 1'b0, st_r.strap};
		pcs_val  = 8'h00;
		pcs_val[`PSL_PCS_CIS] = evt_in.carrier_integrity;
		stat_val = {1'b0, st_r.lstate, st_r.act};

		// hold counters
		st_nxt.col_cnt = stretch(st_r.col_cnt, col_ev);
		if (mode_in.full_duplex)
			st_nxt.col_cnt = '0;
		st_nxt.tx_cnt  = stretch(st_r.tx_cnt, tx_ev);
		st_nxt.rx_cnt  = stretch(st_r.rx_cnt, rx_ev);

		// 10M loss timer restarts on every pulse or packet
		if (lp_ev)
			st_nxt.loss_cnt = LOSS;
		else if (st_r.loss_cnt != '0)
			st_nxt.loss_cnt = st_r.loss_cnt - 1'b1;

		// link qualification
		if (is_10t)
		begin
			st_nxt.qual_cnt = '0;
			case (st_r.lstate)
				PSLED_UP:
				begin
					if (st_r.loss_cnt == '0 && !lp_ev)
					begin
						st_nxt.lstate = PSLED_DOWN;
						st_nxt.lp_cnt = '0;
					end
				end
				default:
				begin
					// a gap longer than the loss time breaks the pulse run
					if (st_r.loss_cnt == '0 && !lp_ev)
						st_nxt.lp_cnt = '0;
					if (evt_in.valid_pkt ||
					    (evt_in.link_pulse && st_r.lp_cnt == `PSL_LP_NEED - 3'h1))
					begin
						st_nxt.lstate = PSLED_UP;
						st_nxt.lp_cnt = '0;
					end
					else if (evt_in.link_pulse)
					begin
						st_nxt.lstate = PSLED_QUAL;
						st_nxt.lp_cnt = st_r.lp_cnt + 3'h1;
					end
				end
			endcase
		end
		else
		begin
			st_nxt.lp_cnt = '0;
			case (st_r.lstate)
				PSLED_DOWN:
				begin
					st_nxt.qual_cnt = '0;
					if (qual_ok)
						st_nxt.lstate = PSLED_QUAL;
				end
				PSLED_QUAL:
				begin
					if (!qual_ok)
					begin
						st_nxt.lstate   = PSLED_DOWN;
						st_nxt.qual_cnt = '0;
					end
					else if (st_r.qual_cnt >= QEND)
						st_nxt.lstate = PSLED_UP;
					else
						st_nxt.qual_cnt = st_r.qual_cnt + 1'b1;
				end
				PSLED_UP:
				begin
					// sync is no longer looked at once up
					if (!hold_ok)
					begin
						st_nxt.lstate   = PSLED_DOWN;
						st_nxt.qual_cnt = '0;
					end
				end
				default:
				begin
					st_nxt.lstate   = PSLED_DOWN;
					st_nxt.qual_cnt = '0;
				end
			endcase
		end

		link_on = mode_in.aui | (st_r.lstate == PSLED_UP);

		// indicator meaning, then pin level by strap
		st_nxt.act[`PSL_COL]  = ~mode_in.full_duplex & (st_r.col_cnt != '0);
		st_nxt.act[`PSL_TX]   = st_r.tx_remap ? evt_in.carrier_integrity
		                                      : (st_r.tx_cnt != '0);
		st_nxt.act[`PSL_RX]   = st_r.rx_cnt != '0;
		st_nxt.act[`PSL_LINK] = link_on;
		st_nxt.act[`PSL_FDP]  = st_r.dup_sel ? mode_in.full_duplex
		                       : (mode_in.speed_10 & evt_in.polarity_inv);
		st_nxt.pin      = st_nxt.act ^ st_r.strap;
		st_nxt.oe       = 1'b1;
		st_nxt.speed    = mode_in.speed_10;
		// the receive path inverts its data while this is high
		st_nxt.pol_flip = mode_in.speed_10 & evt_in.polarity_inv;

		// register port; read data valid only in the cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (bus_in.re)
		begin
			if (bus_in.addr == byte_addr(`PSL_IDX_CTL))
				st_nxt.rdata = ctl_val;
			else if (bus_in.addr == byte_addr(`PSL_IDX_PCS))
				st_nxt.rdata = pcs_val;
			else if (bus_in.addr == byte_addr(`PSL_IDX_STAT))
				st_nxt.rdata = stat_val;
		end
		// strap bits are read only, software may only move the two mode bits
		if (bus_in.we && bus_in.addr == byte_addr(`PSL_IDX_CTL))
		begin
			st_nxt.tx_remap = bus_in.wdata[`PSL_CTL_TXMAP];
			st_nxt.dup_sel  = bus_in.wdata[`PSL_CTL_DUPSEL];
		end

		if (srst_in)
		begin
			st_nxt          = '0;
			// pins are strap inputs during reset, so drivers stay off
			st_nxt.strap    = address_strap_in;
			st_nxt.tx_remap = 1'(`PSL_CTL_RST_HI >> 1);
			st_nxt.dup_sel  = 1'(`PSL_CTL_RST_HI & 2'h1);
			st_nxt.lstate   = PSLED_DOWN;
		end
	end

	always_ff @(posedge clk_in)
	begin
		st_r <= st_nxt;
	end

	assign rd_data_out                   = st_r.rdata;
	assign collision_indicator_out       = st_r.pin[`PSL_COL];
	assign transmit_indicator_out        = st_r.pin[`PSL_TX];
	assign receive_indicator_out         = st_r.pin[`PSL_RX];
	assign link_indicator_out            = st_r.pin[`PSL_LINK];
	assign duplex_polarity_indicator_out = st_r.pin[`PSL_FDP];
	assign indicator_oe_out              = st_r.oe;
	assign low_speed_output_out          = st_r.speed;
	assign rx_polarity_flip_out          = st_r.pol_flip;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// drivers are off in reset, so the level is only meaningful once enabled
	pin_polarity_a: assert property (
		indicator_oe_out |-> ({duplex_polarity_indicator_out, link_indicator_out,
		receive_indicator_out, transmit_indicator_out, collision_indicator_out}
		== (st_r.act ^ st_r.strap)))
		else $error("indicator level does not follow strap");

	strap_capture_a: assert property (
		$fell(srst_in) |-> st_r.strap == $past(address_strap_in))
		else $error("strap not captured at reset");

	col_fd_off_a: assert property (
		mode_in.full_duplex [*2] |-> !st_r.act[`PSL_COL])
		else $error("collision shown in full duplex");

	col_stretch_a: assert property (
		(!mode_in.full_duplex && evt_in.collision) |=> st_r.col_cnt == HOLD)
		else $error("collision hold not reloaded");

	heartbeat_a: assert property (
		(mode_in.speed_10 && !mode_in.full_duplex && evt_in.heartbeat)
		|=> st_r.col_cnt == HOLD)
		else $error("heartbeat missed");

	tx_remap_a: assert property (
		st_r.tx_remap |=> st_r.act[`PSL_TX] == $past(evt_in.carrier_integrity))
		else $error("transmit remap wrong");

	rx_hold_a: assert property (
		evt_in.rx_act |=> ##1 st_r.act[`PSL_RX] [*3])
		else $error("receive not held");

	link_drop_a: assert property (
		(!mode_in.speed_10 && !mode_in.aui && st_r.lstate == PSLED_UP
		 && !hold_ok) |=> st_r.lstate == PSLED_DOWN)
		else $error("link not dropped on detect loss");

	link_qual_a: assert property (
		(!is_10t && $past(st_r.lstate) == PSLED_QUAL && st_r.lstate == PSLED_UP)
		|-> $past(st_r.qual_cnt) >= QEND)
		else $error("link up before qualification");

	aui_link_a: assert property (
		mode_in.aui |=> st_r.act[`PSL_LINK])
		else $error("aui link not shown");

	speed_pin_a: assert property (
		##1 low_speed_output_out == $past(mode_in.speed_10))
		else $error("speed pin wrong");

	dup_sel_a: assert property (
		st_r.dup_sel |=> st_r.act[`PSL_FDP] == $past(mode_in.full_duplex))
		else $error("duplex indicator wrong");

	tx_stretch_a: assert property (
		evt_in.tx_act |=> st_r.tx_cnt == HOLD)
		else $error("transmit hold not reloaded");

	pkt_link_a: assert property (
		(is_10t && evt_in.valid_pkt) |=> st_r.lstate == PSLED_UP)
		else $error("packet did not bring link up");

	pol_flip_a: assert property (
		(mode_in.speed_10 && evt_in.polarity_inv) |=> rx_polarity_flip_out)
		else $error("polarity inversion not corrected");

endmodule : psled_top

`default_nettype wire

// >>> test/psled_led_model.sv
// indicator model: turns pin levels back into lit or dark
// assumes the strap levels that the bench held during reset
`timescale 1ns/100ps
`default_nettype none

module psled_led_model
(
	// pins from the block
	input  wire logic [4:0] pin_in,
	input  wire logic [4:0] strap_in,
	input  wire logic       oe_in,
	// what a viewer sees
	output logic [4:0]      lit_out
);
	// a low strap gives active high drive, so xor undoes the polarity
	assign lit_out = oe_in ? (pin_in ^ strap_in) : 5'h00;
endmodule : psled_led_model

`default_nettype wire

// >>> test/testbench.sv
// self-checking bench of the phy status indicator block
// assumes short hold counts handed to the top through its parameters
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import psled_pkg::*;
	localparam int         SC    = 20;
	localparam int         QC    = 8;
	localparam int         LC    = 50;
	localparam logic [4:0] STRAP = 5'h0a;
	logic        clk_in  = 1'b0;
	logic        srst_in = 1'b1;
	logic [4:0]  strap   = STRAP;
	psled_bus_t  bus     = '0;
	psled_mode_t mode    = '0;
	psled_evt_t  ev      = '0;
	logic [7:0]  rd;
	wire  [4:0]  pins;
	logic [4:0]  lit;
	logic        oe;
	logic        spd;
	logic        flip;
	int          errors          = 0;
	int          samples_checked = 0;

	always #50 clk_in = ~clk_in;

	psled_top #(.STRETCH_CYC(SC), .QUAL_CYC(QC), .LOSS_CYC(LC)) psled_top_inst (
		.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus), .rd_data_out(rd),
		.mode_in(mode), .evt_in(ev), .address_strap_in(strap),
		.collision_indicator_out(pins[0]), .transmit_indicator_out(pins[1]),
		.receive_indicator_out(pins[2]), .link_indicator_out(pins[3]),
		.duplex_polarity_indicator_out(pins[4]), .indicator_oe_out(oe),
		.low_speed_output_out(spd), .rx_polarity_flip_out(flip));

	psled_led_model psled_led_model_inst (.pin_in(pins), .strap_in(STRAP), .oe_in(oe),
		.lit_out(lit));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	task automatic at(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask : at

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_in);
		bus <= '0;
	endtask : wr

	task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_in);
		bus <= '0;
		@(negedge clk_in);
		chk(rd, exp);
	endtask : rdr

	// event bits: 10 col, 9 beat, 8 tx, 7 rx, 6 pulse, 5 pkt, 4 sd, 3 sync, 2 fx sd, 1 pol, 0 cis
	task automatic set(input int b, input logic v);
		@(posedge clk_in);
		ev[b] <= v;
	endtask : set

	task automatic pulse(input int b);
		set(b, 1'b1);
		set(b, 1'b0);
	endtask : pulse

	task automatic setm(input psled_mode_t m);
		@(posedge clk_in);
		mode <= m;
	endtask : setm

	// second event lands before the first hold runs out
	task automatic stretch(input int b, input int led);
		pulse(b);
		at(2);
		chk(lit[led], 1'b1);
		at(12);
		pulse(b);
		at(SC - 4);
		chk(lit[led], 1'b1);
		at(8);
		chk(lit[led], 1'b0);
	endtask : stretch

	// drop b first: it must not matter once the link is up
	task automatic qual(input int a, input int b);
		set(a, 1'b1);
		set(b, 1'b1);
		at(4);
		chk(lit[3], 1'b0);
		at(8);
		chk(lit[3], 1'b1);
		set(b, 1'b0);
		at(3);
		chk(lit[3], 1'b1);
		set(a, 1'b0);
		at(3);
		chk(lit[3], 1'b0);
	endtask : qual

	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	initial
	begin
		repeat (3000) @(posedge clk_in);
		errors++;
		report_and_stop();
	end

	initial
	begin
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		strap <= 5'h15;
		at(3);
		chk(pins, STRAP);
		chk(lit, 5'h00);
		rdr(8'h64, 8'h4a);
		wr(8'h64, 8'hff);
		rdr(8'h64, 8'hca);
		rdr(8'h00, 8'h00);
		wr(8'h64, 8'h40);
		done("registers");
		stretch(7, 2);
		stretch(8, 1);
		stretch(10, 0);
		setm('{1'b0, 1'b1, 1'b0, 1'b0});
		pulse(10);
		at(3);
		chk(lit[0], 1'b0);
		chk(lit[4], 1'b1);
		setm('{1'b1, 1'b0, 1'b0, 1'b0});
		pulse(9);
		at(2);
		chk(lit[0], 1'b1);
		chk(spd, 1'b1);
		at(SC + 4);
		done("activity");
		wr(8'h64, 8'h00);
		set(1, 1'b1);
		at(3);
		chk(lit[4], 1'b1);
		chk(flip, 1'b1);
		set(1, 1'b0);
		wr(8'h64, 8'h80);
		set(0, 1'b1);
		at(3);
		chk(lit[1], 1'b1);
		rdr(8'h58, 8'h10);
		set(0, 1'b0);
		at(3);
		chk(lit[1], 1'b0);
		done("remap");
		repeat (6)
		begin
			pulse(6);
			at(2);
		end
		chk(lit[3], 1'b0);
		pulse(6);
		at(3);
		chk(lit[3], 1'b1);
		rdr(8'h68, 8'h68);
		at(LC + 5);
		chk(lit[3], 1'b0);
		pulse(5);
		at(3);
		chk(lit[3], 1'b1);
		at(LC + 5);
		chk(lit[3], 1'b0);
		setm('{1'b0, 1'b0, 1'b1, 1'b0});
		at(3);
		chk(lit[3], 1'b1);
		setm('0);
		at(3);
		qual(4, 3);
		setm('{1'b0, 1'b0, 1'b0, 1'b1});
		qual(2, 4);
		chk(spd, 1'b0);
		done("link");
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
